// ===== pkg/plc_pkg.sv
// Shared constants and types of the control-loop computation block
package plc_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_MS = 50;
  localparam int BASE_TICK_CYCLES = BASE_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CYCLE_UNIT_MS = 10;
  localparam int CYCLE_STEP = BASE_TICK_MS / CYCLE_UNIT_MS;
  localparam logic [9:0] CYCLE_SET_MIN = 10'h005;
  localparam logic [9:0] CYCLE_SET_MAX = 10'h3E8;
  // Values are in 0.1 percent, times in 0.1 s
  localparam logic signed [15:0] FULL_SCALE = 16'sh03E8;
  localparam logic signed [15:0] SCALE_OUT_HIGH = 16'sh04E2;
  localparam logic signed [15:0] SCALE_OUT_LOW = -16'sh00FA;
  localparam logic [15:0] CUT_POINT_MAX = 16'h04E2;
  localparam logic [15:0] FILTER_TAU_MAX = 16'h2328;
  localparam logic [15:0] INTEGRAL_TIME_MAX = 16'h7D00;
  localparam logic [15:0] DERIV_TIME_MAX = 16'h270F;
  localparam int HYST_SPAN_DIV = 2;
  localparam int FILT_FRAC = 8;
  localparam int INTEG_FRAC = 8;
  localparam logic DIRECT_CODE = 1'b1;
  localparam logic signed [15:0] MV_RESET = 16'sh0000;
  // Limit-mode bits: high side clamps, low side clamps
  localparam int LIM_HIGH_BIT = 1;
  localparam int LIM_LOW_BIT = 0;

  typedef struct packed {
    logic [15:0] proportional_band;
    logic [15:0] integral_time;
    logic [15:0] derivative_time;
    logic [9:0] control_cycle_setting;
    logic [15:0] onoff_hysteresis;
    logic [15:0] input_span;
    logic action_direction;
    logic signed [15:0] integ_window_high;
    logic signed [15:0] integ_window_low;
    logic signed [15:0] output_bias;
    logic [1:0] limit_mode_select;
    logic signed [15:0] out_upper_bound;
    logic signed [15:0] out_lower_bound;
    logic [15:0] out_rate_bound;
  } plc_cfg_t;

  typedef struct packed {
    logic manual;
    logic standby;
    logic ext_fixed;
    logic burnout;
    logic autotune;
  } plc_mode_t;

  typedef struct packed {
    logic [22:0] base_cnt;
    logic [7:0] cyc_cnt;
    logic [2:0][23:0] filt;
    logic signed [31:0] integ;
    logic signed [15:0] err_prev;
    logic signed [15:0] mv;
    logic onoff;
    logic clamp_high;
    logic clamp_low;
    logic [15:0] pb;
    logic [15:0] ti;
    logic [15:0] td;
    logic cycle_done;
  } plc_state_t;
endpackage

// ===== verilog/plc_loop_compute.sv
// Control-loop computation: input conditioning, PID or ON/OFF, output limiting
//
// How it works
// - Square-root extraction maps pressure to flow; below cut point result is zero while the input's sqrt_cut_off bit is clear.
// - First-order lag filter per input, time constant 0.0 to 900.0 s.
// - Limit mode picks clamp or scale-out for high and low sides separately.
// - Manual, standby, fixed output and burnout bypass clamping and scale-out.
// - Limit mode and bounds stay active during auto tuning.
// - While clamped, P and I pushing further past the bound are cut.
// - Output change per control cycle limited by rate bound; zero disables.
// - Rate limit also applies to manually entered output.
// - Proportional band zero selects ON/OFF control with hysteresis.
// - Auto tuning result always leaves a nonzero proportional band.
// - Cycle setting 5..1000 x10 ms truncated to a multiple of 50 ms.
// - Hysteresis in engineering units, limited to half the input span.
// - ON/OFF reverse: on below setpoint; direct action inverts.
// - Integrate only inside setpoint window, inclusive; hold integral outside.
// - Auto tuning leaves window widths and output bias untouched.
// - Second and auxiliary inputs have their own filter and cut point.
`timescale 1ns/1ps
module plc_loop_compute #(
  parameter int TICK_CYCLES = plc_pkg::BASE_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic signed [15:0] in1_raw,
  input wire logic signed [15:0] in2_raw,
  input wire logic signed [15:0] aux_raw,
  input wire logic [2:0] sqrt_enable,
  input wire logic [2:0] sqrt_cut_off,
  input wire logic [15:0] sqrt_cut_point_in1,
  input wire logic [15:0] sqrt_cut_point_in2,
  input wire logic [15:0] sqrt_cut_point_aux,
  input wire logic [15:0] filter_tau_in1,
  input wire logic [15:0] filter_tau_in2,
  input wire logic [15:0] filter_tau_aux,
  input wire logic signed [15:0] setpoint,
  input wire plc_pkg::plc_cfg_t cfg,
  input wire logic cfg_load,
  input wire plc_pkg::plc_mode_t mode,
  input wire logic signed [15:0] manual_value,
  input wire logic signed [15:0] standby_value,
  input wire logic signed [15:0] external_fixed_output,
  input wire logic tune_done,
  input wire logic [15:0] tune_pb,
  input wire logic [15:0] tune_ti,
  input wire logic [15:0] tune_td,
  output logic signed [15:0] mv_out,
  output logic onoff_out,
  output logic signed [15:0] pv1_value,
  output logic signed [15:0] pv2_value,
  output logic signed [15:0] aux_value,
  output logic cycle_done,
  output logic clamp_high,
  output logic clamp_low,
  output logic pid_active
);
  plc_pkg::plc_state_t s;
  plc_pkg::plc_state_t next_s;

  logic signed [2:0][15:0] raw;
  logic [2:0][15:0] cut;
  logic [2:0][15:0] tau;
  logic signed [2:0][15:0] cond;

  // Full scale as unsigned for the root argument
  localparam logic [15:0] FULL_SCALE_U = 16'(plc_pkg::FULL_SCALE);
  // Integer part of the integral kept within 16 bits so it cannot wrap
  localparam logic signed [31:0] INTEG_LIM = 32'sh007F_FFFF;

  // Integer square root, bit by bit
  function automatic logic [15:0] plc_isqrt(input logic [31:0] v);
    logic [15:0] root;
    logic [15:0] cand;
    root = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      cand = root | (16'h0001 << i);
      if ({16'h0000, cand} * {16'h0000, cand} <= {32'h0000_0000, v}) begin
        root = cand;
      end
    end
    return root;
  endfunction

  function automatic logic signed [31:0] plc_sat(input logic signed [31:0] v,
                                                 input logic signed [15:0] hi,
                                                 input logic signed [15:0] lo);
    if (v > 32'(hi)) begin
      return 32'(hi);
    end else if (v < 32'(lo)) begin
      return 32'(lo);
    end
    return v;
  endfunction

  assign raw = {aux_raw, in2_raw, in1_raw};
  assign cut = {sqrt_cut_point_aux, sqrt_cut_point_in2, sqrt_cut_point_in1};
  assign tau = {filter_tau_aux, filter_tau_in2, filter_tau_in1};

  // Each input conditioned on its own settings
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      logic [15:0] pos;
      logic [15:0] flow;
      logic [15:0] cut_lim;
      assign pos = raw[g][15] ? 16'h0000 : raw[g];
      // Flow = sqrt(dp/100%) * 100%, in 0.1 % units
      assign flow = plc_isqrt(32'(pos) * 32'(FULL_SCALE_U));
      assign cut_lim = (cut[g] > plc_pkg::CUT_POINT_MAX) ? plc_pkg::CUT_POINT_MAX : cut[g];
      assign cond[g] = !sqrt_enable[g] ? raw[g] :
                       (!sqrt_cut_off[g] && flow < cut_lim) ? 16'sh0000 :
                       $signed(flow);
    end
  endgenerate

  // Datapath temporaries
  logic base_tick;
  logic ctl_tick;
  logic [9:0] cyc_set;
  logic [7:0] cyc_per;
  logic [15:0] tau_c;
  logic signed [31:0] fdiff;
  logic signed [31:0] pv;
  logic signed [31:0] err;
  logic signed [31:0] dterm;
  logic signed [31:0] u;
  logic signed [31:0] pid_raw;
  logic signed [31:0] target;
  logic signed [31:0] hi_b;
  logic signed [31:0] lo_b;
  logic signed [31:0] limited;
  logic signed [31:0] delta;
  logic signed [31:0] hyst;
  logic signed [31:0] half;
  logic [15:0] hys_eu;
  logic in_window;
  logic bypass;
  logic pid_mode;
  logic on_next;
  // Operands widened as signed: a zero-extended cast would make the whole
  // expression unsigned and break the division of negative errors
  logic signed [31:0] pb_s;
  logic signed [31:0] ti_s;
  logic signed [31:0] td_s;
  logic signed [31:0] n_s;
  logic signed [31:0] rate_s;

  always_comb begin
    next_s = s;
    next_s.cycle_done = 1'b0;
    base_tick = (s.base_cnt == 23'(TICK_CYCLES - 1));
    next_s.base_cnt = base_tick ? 23'h000000 : s.base_cnt + 23'h000001;

    // Gains loaded by software or by tuning; window and bias never touched
    if (tune_done) begin
      next_s.pb = (tune_pb == 16'h0000) ? 16'h0001 : tune_pb;
      next_s.ti = (tune_ti > plc_pkg::INTEGRAL_TIME_MAX) ? plc_pkg::INTEGRAL_TIME_MAX : tune_ti;
      next_s.td = (tune_td > plc_pkg::DERIV_TIME_MAX) ? plc_pkg::DERIV_TIME_MAX : tune_td;
    end else if (cfg_load) begin
      next_s.pb = cfg.proportional_band;
      next_s.ti = (cfg.integral_time > plc_pkg::INTEGRAL_TIME_MAX) ?
                  plc_pkg::INTEGRAL_TIME_MAX : cfg.integral_time;
      next_s.td = (cfg.derivative_time > plc_pkg::DERIV_TIME_MAX) ?
                  plc_pkg::DERIV_TIME_MAX : cfg.derivative_time;
    end

    // Filters step every 50 ms: y += (x - y) / (2*tau + 1), tau in 0.1 s
    tau_c = 16'h0000;
    fdiff = 32'sh0000_0000;
    for (int c = 0; c < 3; c++) begin
      tau_c = (tau[c] > plc_pkg::FILTER_TAU_MAX) ? plc_pkg::FILTER_TAU_MAX : tau[c];
      fdiff = (32'($signed(cond[c])) <<< plc_pkg::FILT_FRAC) - 32'($signed(s.filt[c]));
      if (base_tick) begin
        next_s.filt[c] = 24'($signed(s.filt[c]) + fdiff / (32'(tau_c) * 2 + 1));
      end
    end

    // Cycle length truncated to whole 50 ms ticks
    cyc_set = cfg.control_cycle_setting;
    if (cyc_set < plc_pkg::CYCLE_SET_MIN) begin
      cyc_set = plc_pkg::CYCLE_SET_MIN;
    end else if (cyc_set > plc_pkg::CYCLE_SET_MAX) begin
      cyc_set = plc_pkg::CYCLE_SET_MAX;
    end
    cyc_per = 8'(cyc_set / 10'(plc_pkg::CYCLE_STEP));
    ctl_tick = base_tick && (s.cyc_cnt + 8'h01 >= cyc_per);
    if (base_tick) begin
      next_s.cyc_cnt = ctl_tick ? 8'h00 : s.cyc_cnt + 8'h01;
    end
    pb_s = $signed({16'h0000, s.pb});
    ti_s = $signed({16'h0000, s.ti});
    td_s = $signed({16'h0000, s.td});
    n_s = $signed({24'h000000, cyc_per});
    rate_s = $signed({16'h0000, cfg.out_rate_bound});

    pv = 32'($signed(s.filt[0]) >>> plc_pkg::FILT_FRAC);
    err = (cfg.action_direction == plc_pkg::DIRECT_CODE) ?
          pv - 32'(setpoint) : 32'(setpoint) - pv;
    in_window = (pv >= 32'(setpoint) - 32'(cfg.integ_window_low)) &&
                (pv <= 32'(setpoint) + 32'(cfg.integ_window_high));
    pid_mode = (s.pb != 16'h0000);
    bypass = mode.manual | mode.standby | mode.ext_fixed | mode.burnout;

    // Derivative on error over the cycle length, cycle in 0.5 units of 0.1 s
    dterm = (s.td == 16'h0000) ? 32'sh0000_0000 :
            td_s * (err - 32'(s.err_prev)) * 2 / n_s;
    u = err + (s.integ >>> plc_pkg::INTEG_FRAC) + dterm;
    pid_raw = pid_mode ? u * 32'(plc_pkg::FULL_SCALE) / pb_s + 32'(cfg.output_bias) :
              32'sh0000_0000;

    // Hysteresis capped at half span, then expressed in 0.1 % of span
    hys_eu = (cfg.onoff_hysteresis > cfg.input_span / 16'(plc_pkg::HYST_SPAN_DIV)) ?
             cfg.input_span / 16'(plc_pkg::HYST_SPAN_DIV) : cfg.onoff_hysteresis;
    hyst = (cfg.input_span == 16'h0000) ? 32'sh0000_0000 :
           32'(hys_eu) * 32'(plc_pkg::FULL_SCALE) / 32'(cfg.input_span);
    half = hyst / 2;
    on_next = s.onoff;
    if (err > half) begin
      on_next = 1'b1;
    end else if (err < -half) begin
      on_next = 1'b0;
    end

    target = pid_mode ? pid_raw : (on_next ? 32'(plc_pkg::FULL_SCALE) : 32'sh0000_0000);
    if (mode.manual) begin
      target = 32'(manual_value);
    end else if (mode.ext_fixed) begin
      target = 32'(external_fixed_output);
    end else if (mode.standby) begin
      target = 32'(standby_value);
    end else if (mode.burnout) begin
      target = 32'(s.mv);
    end

    // Bounds also hold during auto tuning: the tune flag is not a bypass
    hi_b = cfg.limit_mode_select[plc_pkg::LIM_HIGH_BIT] ?
           32'(cfg.out_upper_bound) : 32'(plc_pkg::SCALE_OUT_HIGH);
    lo_b = cfg.limit_mode_select[plc_pkg::LIM_LOW_BIT] ?
           32'(cfg.out_lower_bound) : 32'(plc_pkg::SCALE_OUT_LOW);
    if (bypass) begin
      limited = plc_sat(target, 16'sh7FFF, -16'sh7FFF);
    end else begin
      limited = plc_sat(target, 16'(hi_b), 16'(lo_b));
    end

    // Rate bound covers manual entries too
    delta = limited - 32'(s.mv);
    if (cfg.out_rate_bound != 16'h0000) begin
      if (delta > rate_s) begin
        limited = 32'(s.mv) + rate_s;
      end else if (delta < -rate_s) begin
        limited = 32'(s.mv) - rate_s;
      end
    end

    if (ctl_tick) begin
      next_s.cycle_done = 1'b1;
      next_s.mv = 16'(limited);
      next_s.onoff = pid_mode ? 1'b0 : on_next;
      next_s.err_prev = 16'(plc_sat(err, 16'sh7FFF, -16'sh7FFF));
      next_s.clamp_high = !bypass && target > hi_b;
      next_s.clamp_low = !bypass && target < lo_b;
      // Integral held outside window, in bypass, and against an active clamp
      if (!pid_mode || s.ti == 16'h0000) begin
        next_s.integ = 32'sh0000_0000;
      end else if (in_window && !bypass &&
                   !(s.clamp_high && err > 0) && !(s.clamp_low && err < 0)) begin
        next_s.integ = s.integ + err * n_s * (1 << (plc_pkg::INTEG_FRAC - 1)) /
                       ti_s;
      end
      if (next_s.integ > INTEG_LIM) begin
        next_s.integ = INTEG_LIM;
      end else if (next_s.integ < -INTEG_LIM) begin
        next_s.integ = -INTEG_LIM;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.mv <= plc_pkg::MV_RESET;
      s.pb <= 16'h0001;
    end else begin
      s <= next_s;
    end
  end

  // Clamp flags only gate the integral; the P push past a bound is cut by the bound itself
  assign mv_out = s.mv;
  assign onoff_out = s.onoff;
  assign pv1_value = 16'($signed(s.filt[0]) >>> plc_pkg::FILT_FRAC);
  assign pv2_value = 16'($signed(s.filt[1]) >>> plc_pkg::FILT_FRAC);
  assign aux_value = 16'($signed(s.filt[2]) >>> plc_pkg::FILT_FRAC);
  assign cycle_done = s.cycle_done;
  assign clamp_high = s.clamp_high;
  assign clamp_low = s.clamp_low;
  assign pid_active = (s.pb != 16'h0000);
endmodule

// ===== bench/plc_loop_props.sv
// Port checker for the control-loop computation block
`timescale 1ns/1ps
module plc_loop_props (
  input wire logic clk,
  input wire logic rstn,
  input wire plc_pkg::plc_cfg_t cfg,
  input wire plc_pkg::plc_mode_t mode,
  input wire logic signed [15:0] manual_value,
  input wire logic signed [15:0] external_fixed_output,
  input wire logic tune_done,
  input wire logic signed [15:0] mv_out,
  input wire logic onoff_out,
  input wire logic cycle_done,
  input wire logic pid_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic byp;
  logic fix;
  // Rate limit off makes the issued value equal the target after the bounds
  assign byp = mode.manual | mode.standby | mode.ext_fixed | mode.burnout;
  assign fix = cfg.out_rate_bound == 16'h0000;
  done_pulse_a: assert property (cycle_done |=> !cycle_done)
    else $error("cycle_done wider than one clock");
  mv_change_a: assert property ($changed(mv_out) |-> cycle_done)
    else $error("mv_out changed outside a control cycle");
  bound_high_a: assert property (cycle_done && $past(!byp && fix && cfg.limit_mode_select[1])
    |-> mv_out <= $past(cfg.out_upper_bound)) else $error("mv_out above upper bound");
  bound_low_a: assert property (cycle_done && $past(!byp && fix && cfg.limit_mode_select[0])
    |-> mv_out >= $past(cfg.out_lower_bound)) else $error("mv_out below lower bound");
  scale_range_a: assert property (cycle_done && $past(!byp && fix)
    |-> mv_out <= plc_pkg::SCALE_OUT_HIGH && mv_out >= plc_pkg::SCALE_OUT_LOW)
    else $error("mv_out beyond scale-out points");
  rate_step_a: assert property (cycle_done && $past(!fix)
    |-> int'(mv_out) - int'($past(mv_out)) <= int'($past(cfg.out_rate_bound))
    && int'($past(mv_out)) - int'(mv_out) <= int'($past(cfg.out_rate_bound)))
    else $error("mv_out step above rate bound");
  ext_fixed_a: assert property (cycle_done && $past(fix && mode.ext_fixed && !mode.manual)
    |-> mv_out == $past(external_fixed_output)) else $error("fixed output not issued");
  manual_out_a: assert property (cycle_done && $past(fix && mode.manual)
    |-> mv_out == $past(manual_value)) else $error("manual value not issued");
  onoff_pid_a: assert property (cycle_done && $past(pid_active) |-> !onoff_out)
    else $error("two-position output active in PID mode");
  tune_pid_a: assert property (tune_done |=> pid_active)
    else $error("tuning left a zero band");
  cover property (cycle_done && onoff_out);
  cover property (cycle_done && mode.manual);
  cover property (tune_done);
  cover property (cycle_done && mode.standby);
endmodule
bind plc_loop_compute plc_loop_props u_props (.clk, .rstn, .cfg, .mode, .manual_value,
  .external_fixed_output, .tune_done, .mv_out, .onoff_out, .cycle_done, .pid_active);

// ===== bench/plc_loop_compute_tb.sv
// Self-checking testbench of the control-loop computation block
`timescale 1ns/1ps
module plc_loop_compute_tb;
  localparam int TK = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic signed [15:0] in1_raw = '0, in2_raw = '0, aux_raw = '0, setpoint = '0;
  logic signed [15:0] manual_value = '0, standby_value = '0, external_fixed_output = '0;
  logic [2:0] sqrt_enable = '0, sqrt_cut_off = '0;
  logic [15:0] sqrt_cut_point_in1 = '0, sqrt_cut_point_in2 = '0, sqrt_cut_point_aux = '0;
  logic [15:0] filter_tau_in1 = '0, filter_tau_in2 = '0, filter_tau_aux = '0;
  logic [15:0] tune_pb = '0, tune_ti = '0, tune_td = '0;
  logic cfg_load = 1'b0, tune_done = 1'b0;
  plc_pkg::plc_cfg_t cfg = '0;
  plc_pkg::plc_mode_t mode = '0;
  logic signed [15:0] mv_out, pv1_value, pv2_value, aux_value;
  logic onoff_out, cycle_done, clamp_high, clamp_low, pid_active;
  int errors = 0, checks_done = 0, gap;

  plc_loop_compute #(.TICK_CYCLES(TK)) DUT (.clk, .rstn, .in1_raw, .in2_raw, .aux_raw,
    .sqrt_enable, .sqrt_cut_off, .sqrt_cut_point_in1, .sqrt_cut_point_in2,
    .sqrt_cut_point_aux, .filter_tau_in1, .filter_tau_in2, .filter_tau_aux, .setpoint,
    .cfg, .cfg_load, .mode, .manual_value, .standby_value, .external_fixed_output,
    .tune_done, .tune_pb, .tune_ti, .tune_td, .mv_out, .onoff_out, .pv1_value, .pv2_value,
    .aux_value, .cycle_done, .clamp_high, .clamp_low, .pid_active);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Counts clocks to the next cycle_done into gap
  task automatic wait_done();
    gap = 0;
    do begin
      step();
      gap++;
    end while (cycle_done !== 1'b1 && gap < 400);
    if (gap >= 400) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic settle(int k);
    repeat (k) wait_done();
  endtask

  task automatic load();
    cfg_load = 1'b1;
    step();
    cfg_load = 1'b0;
  endtask

  task automatic t_input();
    in1_raw = 16'sh0190;
    in2_raw = 16'sh00FA;
    aux_raw = 16'sh0010;
    sqrt_enable = 3'h6;
    sqrt_cut_off = 3'h2;
    sqrt_cut_point_in2 = 16'h04E2;
    sqrt_cut_point_aux = 16'h00C8;
    settle(2);
    chk("pv1", pv1_value, 16'h0190);
    chk("pv2", pv2_value, 16'h01F4);
    chk("aux", aux_value, 16'h0000);
  endtask

  task automatic t_limit();
    cfg.proportional_band = 16'h03E8;
    cfg.out_upper_bound = 16'sh0258;
    cfg.out_lower_bound = 16'sh0064;
    load();
    setpoint = 16'sh0384;
    in1_raw = '0;
    mode.autotune = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg.limit_mode_select = 2'(i);
      cfg.action_direction = 1'b0;
      settle(3);
      chk("mv high", mv_out, i[1] ? 16'h0258 : 16'h0384);
      chk("clamp high", clamp_high, 16'(i[1]));
      cfg.action_direction = 1'b1;
      settle(3);
      chk("mv low", mv_out, i[0] ? 16'h0064 : 16'hFF06);
      chk("clamp low", clamp_low, 16'h0001);
    end
    mode.autotune = 1'b0;
  endtask

  task automatic t_bypass();
    mode.manual = 1'b1;
    manual_value = 16'sh044C;
    settle(2);
    chk("manual mv", mv_out, 16'h044C);
    mode.manual = 1'b0;
    mode.standby = 1'b1;
    standby_value = 16'sh0384;
    settle(2);
    chk("standby mv", mv_out, 16'h0384);
    mode.standby = 1'b0;
    mode.ext_fixed = 1'b1;
    external_fixed_output = 16'sh04B0;
    settle(2);
    chk("fixed mv", mv_out, 16'h04B0);
    mode.ext_fixed = 1'b0;
    mode.burnout = 1'b1;
    settle(2);
    chk("burnout mv", mv_out, 16'h04B0);
    mode.burnout = 1'b0;
    mode.manual = 1'b1;
    manual_value = '0;
    cfg.out_rate_bound = 16'h0032;
    wait_done();
    chk("rate 1", mv_out, 16'h047E);
    wait_done();
    chk("rate 2", mv_out, 16'h044C);
    mode.manual = 1'b0;
    cfg.out_rate_bound = '0;
  endtask

  task automatic t_onoff();
    cfg.proportional_band = '0;
    cfg.out_upper_bound = 16'sh03E8;
    cfg.out_lower_bound = '0;
    cfg.action_direction = 1'b0;
    load();
    setpoint = 16'sh01F4;
    in1_raw = 16'sh0190;
    settle(3);
    chk("on rev", onoff_out, 16'h0001);
    chk("pid", pid_active, 16'h0000);
    chk("on mv", mv_out, 16'h03E8);
    cfg.action_direction = 1'b1;
    settle(3);
    chk("off dir", onoff_out, 16'h0000);
    // Width above half span must be cut back to half span
    cfg.onoff_hysteresis = 16'h0320;
    in1_raw = 16'sh02E4;
    settle(3);
    chk("inside band", onoff_out, 16'h0000);
    in1_raw = 16'sh02F8;
    settle(3);
    chk("past band", onoff_out, 16'h0001);
  endtask

  task automatic t_tune();
    tune_done = 1'b1;
    step();
    tune_done = 1'b0;
    chk("tuned pid", pid_active, 16'h0001);
    settle(2);
    chk("tuned onoff", onoff_out, 16'h0000);
  endtask

  task automatic t_cycle();
    cfg.control_cycle_setting = 10'h00E;
    settle(2);
    chk("gap 14", 16'(gap), 16'(2 * TK));
    cfg.control_cycle_setting = 10'h009;
    settle(2);
    chk("gap 9", 16'(gap), 16'(TK));
  endtask

  // Integral steps one output unit per cycle inside the window
  task automatic t_integ();
    int m;
    cfg.proportional_band = 16'h03E8;
    cfg.integral_time = 16'h0019;
    cfg.action_direction = 1'b0;
    cfg.limit_mode_select = 2'h0;
    cfg.integ_window_high = 16'sh0064;
    cfg.integ_window_low = 16'sh0064;
    setpoint = 16'sh01F4;
    in1_raw = 16'sh01C2;
    load();
    settle(3);
    m = mv_out;
    wait_done();
    chk("integ in", 16'(mv_out - m), 16'h0001);
    cfg.integ_window_low = 16'sh000A;
    wait_done();
    m = mv_out;
    wait_done();
    chk("integ held", 16'(mv_out - m), 16'h0000);
    cfg.integral_time = '0;
    load();
    settle(2);
    chk("p only", mv_out, 16'h0032);
  endtask

  initial begin
    cfg.control_cycle_setting = 10'h005;
    cfg.input_span = 16'h03E8;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_input();
    t_limit();
    t_bypass();
    t_onoff();
    t_tune();
    t_cycle();
    t_integ();
    finish_test();
  end
endmodule
